/* File: rtl/lpam_top.sv */
// module: activity monitor, standby entry paths and wake logic behind an APB slave
// What this block does
// - poll each bus input at least every 4 ms
// - mask bus inputs while we are transmitting
// - count steps of 0.65536 s since activity
// - eight-bit count saturates at FF
// - monitor disabled until first bus send
// - monitor held disabled while in bus monitoring
// - master enable bit 7 gates all entries
// - low power command enters standby after 1 s
// - standby: outputs off, voltage low, invert power
// - serial timeout needs power bits 7 and 5
// - serial timeout 5 or 20 minutes by b4
// - b3 sends activity alert 1 minute early
// - serial expiry: low power alert, standby 2 s later
// - bus standby needs monitor b7,b5 and power b7
// - bus timeout from b4 unless command overrides
// - timeout 00 suppresses all monitor outputs
// - monitor can alert without ever sleeping
// - ignition low enters only with b2 and b7
// - debounce ignition, alert, standby 2 s later
// - count query returns current eight-bit count
// - rx low 128 us wakes from standby
// - ignition low then high always wakes
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lpam_top #(
    parameter int unsigned N_BUS      = 4,
    parameter int unsigned STEP_CYCLES = lpam_pkg::STEP_CYC,
    parameter int unsigned POLL_CYCLES = lpam_pkg::POLL_CYC,
    parameter int unsigned LP_CYCLES  = lpam_pkg::LP_DELAY_CYC,
    parameter int unsigned ALERT_CYCLES = lpam_pkg::ALERT_DELAY_CYC,
    parameter int unsigned SEC_CYCLES = lpam_pkg::SEC_CYC,
    parameter int unsigned DEB_CYCLES = lpam_pkg::DEBOUNCE_CYC
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [N_BUS-1:0] bus_in,
    input  wire logic             bus_tx_active,
    input  wire logic             bus_send_start,
    input  wire logic             serial_rx,
    input  wire logic             ignition_monitor_input,
    output logic                  standby,
    output logic                  outputs_off,
    output logic                  j1850_vctl,
    output logic                  power_ctl,
    output lpam_pkg::lpam_msg_s   msg
);

    // ---------------- APB slave ----------------
    wire acc    = psel & penable & clk_en;
    wire wr     = acc & pwrite;
    wire rd     = acc & ~pwrite;
    wire rd_set = psel & ~penable & ~pwrite;
    wire a_ctrl = paddr == lpam_pkg::ADDR_CTRL;
    wire a_par  = paddr == lpam_pkg::ADDR_PARAM;
    wire a_tmo  = paddr == lpam_pkg::ADDR_TIMEOUT;
    wire a_sts  = paddr == lpam_pkg::ADDR_STATUS;
    wire a_cnt  = paddr == lpam_pkg::ADDR_COUNT;
    wire mapped = a_ctrl | a_par | a_tmo | a_sts | a_cnt;

    logic [7:0]  power_control_param;
    logic [7:0]  activity_monitor_param;
    logic [7:0]  amt_value;
    logic        amt_set;
    logic        bus_mon;
    logic [7:0]  act_count;
    logic        mon_enabled;
    lpam_pkg::lpam_state_e state;

    wire lp_cmd   = wr & a_ctrl & pwdata[lpam_pkg::CT_LP_CMD];
    wire tmo_clr  = wr & a_ctrl & pwdata[lpam_pkg::CT_TMO_CLR];
    wire query    = rd & a_cnt;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    wire [31:0] rd_mux =
        a_ctrl ? {29'h0, bus_mon, 2'h0} :
        a_par  ? {16'h0, activity_monitor_param, power_control_param} :
        a_tmo  ? {23'h0, amt_set, amt_value} :
        a_sts  ? {28'h0, mon_enabled, standby, state} :
        a_cnt  ? {24'h0, act_count} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata                 <= 32'h0;
            power_control_param    <= lpam_pkg::PC_RESET;
            activity_monitor_param <= lpam_pkg::AM_RESET;
            amt_value              <= 8'h00;
            amt_set                <= 1'b0;
            bus_mon                <= 1'b0;
        end else if (clk_en) begin
            // captured in setup so read data stands at the access edge
            if (rd_set) begin
                prdata <= rd_mux;
            end
            if (wr & a_par) begin
                power_control_param    <= pwdata[7:0];
                activity_monitor_param <= pwdata[15:8];
            end
            if (wr & a_tmo) begin
                amt_value <= pwdata[7:0];
                amt_set   <= 1'b1;
            end else if (tmo_clr) begin
                amt_set <= 1'b0;
            end
            if (wr & a_ctrl) begin
                bus_mon <= pwdata[lpam_pkg::CT_BUS_MON];
            end
        end
    end

    // ---------------- activity monitor ----------------
    wire master_en = power_control_param[lpam_pkg::PC_MASTER];
    logic [$clog2(POLL_CYCLES+1)-1:0] poll_cnt;
    logic [$clog2(STEP_CYCLES+1)-1:0] step_cnt;
    logic                             seen;
    wire poll_tick = poll_cnt == '0;
    wire step_tick = step_cnt == '0;
    // samples land on every poll tick, exactly at the 4 ms bound
    wire bus_hit   = poll_tick & ~bus_tx_active & (|bus_in);
    wire mon_run   = mon_enabled & ~bus_mon & ~standby;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_enabled <= 1'b0;
            poll_cnt    <= '0;
            step_cnt    <= '0;
            act_count   <= 8'h00;
            seen        <= 1'b0;
        end else if (clk_en) begin
            if (bus_send_start) begin
                mon_enabled <= 1'b1;
            end
            poll_cnt <= poll_tick ? ($bits(poll_cnt))'(POLL_CYCLES - 1) : poll_cnt - 1'b1;
            seen     <= bus_hit;
            if (!mon_run || bus_hit) begin
                step_cnt  <= ($bits(step_cnt))'(STEP_CYCLES - 1);
                act_count <= 8'h00;
            end else if (step_tick) begin
                step_cnt <= ($bits(step_cnt))'(STEP_CYCLES - 1);
                if (act_count != lpam_pkg::CNT_MAX) begin
                    act_count <= act_count + 8'h01;
                end
            end else begin
                step_cnt <= step_cnt - 1'b1;
            end
        end
    end

    wire [7:0] am_limit = amt_set ? amt_value :
        (activity_monitor_param[lpam_pkg::AM_LONG] ? lpam_pkg::AM_LONG_STEPS : lpam_pkg::AM_SHORT_STEPS);
    wire am_out_ok = mon_run & (am_limit != 8'h00)
                   & activity_monitor_param[lpam_pkg::AM_EN];
    wire am_expire = am_out_ok & step_tick & (act_count + 8'h01 == am_limit);
    wire am_alert  = am_expire & activity_monitor_param[lpam_pkg::AM_ALERT_EN];
    wire am_sleep  = am_expire & activity_monitor_param[lpam_pkg::AM_LP_EN] & master_en;

    // ---------------- serial inactivity ----------------
    logic [$clog2(SEC_CYCLES+1)-1:0] sec_cnt;
    logic [10:0]                     ser_secs;
    logic                            rx_q;
    wire sec_tick   = sec_cnt == '0;
    wire rx_edge    = rx_q ^ serial_rx;
    wire [10:0] ser_limit = power_control_param[lpam_pkg::PC_SER_LONG] ?
                            11'(lpam_pkg::SER_LONG_S) : 11'(lpam_pkg::SER_SHORT_S);
    wire ser_en     = master_en & power_control_param[lpam_pkg::PC_SER_EN];
    wire ser_step   = ser_en & (state == lpam_pkg::LPAM_RUN) & sec_tick;
    wire ser_warn   = ser_step & power_control_param[lpam_pkg::PC_SER_WARN]
                    & (ser_secs + 11'(lpam_pkg::SER_WARN_S) + 11'h1 == ser_limit);
    wire ser_expire = ser_step & (ser_secs + 11'h1 == ser_limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_cnt  <= '0;
            ser_secs <= 11'h000;
            rx_q     <= 1'b1;
        end else if (clk_en) begin
            rx_q    <= serial_rx;
            sec_cnt <= (sec_tick || rx_edge) ? ($bits(sec_cnt))'(SEC_CYCLES - 1) : sec_cnt - 1'b1;
            if (rx_edge || !ser_en || state != lpam_pkg::LPAM_RUN) begin
                ser_secs <= 11'h000;
            end else if (ser_step && ser_secs != ser_limit) begin
                ser_secs <= ser_secs + 11'h001;
            end
        end
    end

    // ---------------- ignition debounce ----------------
    logic                            ign_stable;
    logic                            ign_low_seen;
    logic [$clog2(DEB_CYCLES+1)-1:0] deb_cnt;
    logic ign_q_diff;
    assign ign_q_diff = ignition_monitor_input != ign_stable;
    wire ign_go_low  = ign_q_diff & (deb_cnt == '0) & ign_stable;
    wire ign_go_high = ign_q_diff & (deb_cnt == '0) & ~ign_stable;
    wire ign_entry   = ign_go_low & master_en
                     & power_control_param[lpam_pkg::PC_IGN_EN]
                     & (state == lpam_pkg::LPAM_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ign_stable   <= 1'b1;
            ign_low_seen <= 1'b0;
            deb_cnt      <= '0;
        end else if (clk_en) begin
            if (!ign_q_diff) begin
                deb_cnt <= ($bits(deb_cnt))'(DEB_CYCLES - 1);
            end else if (deb_cnt != '0) begin
                deb_cnt <= deb_cnt - 1'b1;
            end else begin
                ign_stable <= ignition_monitor_input;
            end
            if (!standby) begin
                ign_low_seen <= 1'b0;
            end else if (ign_go_low || !ign_stable) begin
                ign_low_seen <= 1'b1;
            end
        end
    end

    // ---------------- rx wake detect ----------------
    localparam int unsigned WAKE_RX_CYCLES_W = lpam_pkg::WAKE_RX_CYC;
    logic [$clog2(WAKE_RX_CYCLES_W+1)-1:0] rx_low_cnt;
    wire rx_wake  = standby & ~serial_rx & (rx_low_cnt == ($bits(rx_low_cnt))'(WAKE_RX_CYCLES_W - 1));
    wire ign_wake = standby & ign_low_seen & ign_go_high;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_low_cnt <= '0;
        end else if (clk_en) begin
            if (!standby || serial_rx) begin
                rx_low_cnt <= '0;
            end else if (!rx_wake) begin
                rx_low_cnt <= rx_low_cnt + 1'b1;
            end
        end
    end

    // ---------------- standby sequencer ----------------
    logic [$clog2(ALERT_CYCLES+LP_CYCLES+1)-1:0] dly_cnt;
    lpam_pkg::lpam_state_e next_state;
    wire alert_go = ser_expire | ign_entry | am_sleep;
    wire cmd_go   = lp_cmd & master_en & (state == lpam_pkg::LPAM_RUN);

    always_comb begin
        next_state = state;
        case (state)
            lpam_pkg::LPAM_RUN: begin
                if (cmd_go || alert_go) begin
                    next_state = lpam_pkg::LPAM_DELAY;
                end
            end
            lpam_pkg::LPAM_DELAY: begin
                if (dly_cnt == '0) begin
                    next_state = lpam_pkg::LPAM_SLEEP;
                end
            end
            lpam_pkg::LPAM_SLEEP: begin
                if (rx_wake || ign_wake) begin
                    next_state = lpam_pkg::LPAM_RUN;
                end
            end
            default: next_state = lpam_pkg::LPAM_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= lpam_pkg::LPAM_RUN;
            dly_cnt <= '0;
            msg     <= '0;
        end else if (clk_en) begin
            state           <= next_state;
            msg.act_alert   <= ser_warn | am_alert;
            msg.low_power_alert_message    <= (state == lpam_pkg::LPAM_RUN) & ~cmd_go & alert_go;
            msg.count_reply <= query;
            if (state == lpam_pkg::LPAM_RUN) begin
                dly_cnt <= cmd_go ? ($bits(dly_cnt))'(LP_CYCLES - 1) : ($bits(dly_cnt))'(ALERT_CYCLES - 1);
            end else if (dly_cnt != '0) begin
                dly_cnt <= dly_cnt - 1'b1;
            end
        end
    end

    // standby output changes, power control inverted while asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby     <= 1'b0;
            outputs_off <= 1'b0;
            j1850_vctl  <= 1'b1;
            power_ctl   <= 1'b1;
        end else if (clk_en) begin
            standby     <= next_state == lpam_pkg::LPAM_SLEEP;
            outputs_off <= next_state == lpam_pkg::LPAM_SLEEP;
            j1850_vctl  <= next_state != lpam_pkg::LPAM_SLEEP;
            power_ctl   <= next_state != lpam_pkg::LPAM_SLEEP;
        end
    end

    a_count_saturates: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && $past(act_count) == lpam_pkg::CNT_MAX && act_count != 8'h00 |-> act_count == lpam_pkg::CNT_MAX)
        else $error("activity count wrapped");
    a_tx_masked: assert property (@(posedge pclk) disable iff (!presetn)
        bus_tx_active |-> !bus_hit) else $error("own transmission counted");
    a_disabled_reset: assert property (@(posedge pclk) disable iff (!presetn)
        !mon_enabled |-> act_count == 8'h00) else $error("count moved while disabled");
    a_mon_hold: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && bus_mon |=> act_count == 8'h00) else $error("count moved in monitoring mode");
    a_master_gate: assert property (@(posedge pclk) disable iff (!presetn)
        state == lpam_pkg::LPAM_RUN && !master_en |=> state == lpam_pkg::LPAM_RUN)
        else $error("standby entry without master enable");
    a_sleep_outputs: assert property (@(posedge pclk) disable iff (!presetn)
        standby |-> outputs_off && !j1850_vctl && !power_ctl) else $error("standby outputs wrong");
    a_zero_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        amt_set && amt_value == 8'h00 |-> !am_alert && !am_sleep) else $error("timeout 00 not suppressing");
    a_ign_gate: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ign_entry |=> state == lpam_pkg::LPAM_DELAY) else $error("ignition gate");
    a_clear_hit: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && bus_hit |=> act_count == 8'h00) else $error("activity did not clear count");

    // poll, count, sequencing, alert and wake checks
    a_poll_bound: assert property (@(posedge pclk) disable iff (!presetn)
        poll_cnt < POLL_CYCLES)
        else $error("poll interval too long");
    a_seen_clears: assert property (@(posedge pclk) disable iff (!presetn)
        seen |-> act_count == 8'h00)
        else $error("count kept after activity");
    a_step_count: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && mon_run && !bus_hit && step_tick && act_count != lpam_pkg::CNT_MAX
        |=> act_count == $past(act_count) + 8'h01)
        else $error("count missed a step");
    a_send_enables: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && bus_send_start |=> mon_enabled)
        else $error("send did not enable monitor");
    a_cmd_delay: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && cmd_go |=> state == lpam_pkg::LPAM_DELAY && !msg.low_power_alert_message)
        else $error("command did not start delay");
    a_delay_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state == lpam_pkg::LPAM_DELAY && dly_cnt == '0 |=> standby)
        else $error("delay end without standby");
    a_standby_state: assert property (@(posedge pclk) disable iff (!presetn)
        standby == (state == lpam_pkg::LPAM_SLEEP))
        else $error("standby flag out of step");
    a_warn_alert: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ser_warn |=> msg.act_alert)
        else $error("serial warning not sent");
    a_ser_alert: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ser_expire && !cmd_go |=> msg.low_power_alert_message)
        else $error("serial expiry alert not sent");
    a_low_power_alert_message_delay: assert property (@(posedge pclk) disable iff (!presetn)
        msg.low_power_alert_message |-> state == lpam_pkg::LPAM_DELAY)
        else $error("alert outside standby delay");
    a_count_reply: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && query |=> msg.count_reply)
        else $error("count query not answered");
    a_rx_wake: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && rx_wake |=> !standby)
        else $error("rx pulse did not wake");
    a_ign_wake: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && ign_wake |=> !standby)
        else $error("ignition did not wake");

endmodule : lpam_top
`default_nettype wire

/* File: rtl/lpam_pkg.sv */
// package: constants and carrier types for the low power entry and activity monitor
package lpam_pkg;

    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned AWORD           = 12;
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_PARAM      = 12'h004;
    localparam logic [11:0] ADDR_TIMEOUT    = 12'h008;
    localparam logic [11:0] ADDR_STATUS     = 12'h00C;
    localparam logic [11:0] ADDR_COUNT      = 12'h010;

    // power control parameter bits
    localparam int unsigned PC_MASTER       = 7;
    localparam int unsigned PC_SER_EN       = 5;
    localparam int unsigned PC_SER_LONG     = 4;
    localparam int unsigned PC_SER_WARN     = 3;
    localparam int unsigned PC_IGN_EN       = 2;
    // activity monitor parameter bits
    localparam int unsigned AM_EN           = 7;
    localparam int unsigned AM_LP_EN        = 5;
    localparam int unsigned AM_LONG         = 4;
    localparam int unsigned AM_ALERT_EN     = 3;

    localparam logic [7:0]  PC_RESET        = 8'hFF;
    localparam logic [7:0]  AM_RESET        = 8'hF8;
    localparam logic [7:0]  AM_SHORT_STEPS  = 8'h1C;
    localparam logic [7:0]  AM_LONG_STEPS   = 8'hFF;
    localparam logic [7:0]  CNT_MAX         = 8'hFF;

    // control register bits (bits 0 and 1 write one to act, bit 2 holds the level written)
    localparam int unsigned CT_LP_CMD       = 0;
    localparam int unsigned CT_TMO_CLR      = 1;
    localparam int unsigned CT_BUS_MON      = 2;

    // times in their own units
    localparam int unsigned POLL_US         = 4_000;
    localparam int unsigned STEP_US         = 655_360;
    localparam int unsigned LP_DELAY_MS     = 1_000;
    localparam int unsigned ALERT_DELAY_MS  = 2_000;
    localparam int unsigned SER_SHORT_S     = 300;
    localparam int unsigned SER_LONG_S      = 1_200;
    localparam int unsigned SER_WARN_S      = 60;
    localparam int unsigned DEBOUNCE_MS     = 50;
    localparam int unsigned WAKE_RX_US      = 128;

    localparam int unsigned POLL_CYC        = POLL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned STEP_CYC        = STEP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LP_DELAY_CYC    = LP_DELAY_MS * (CLK_HZ / 1_000);
    localparam int unsigned ALERT_DELAY_CYC = ALERT_DELAY_MS * (CLK_HZ / 1_000);
    localparam int unsigned SEC_CYC         = CLK_HZ;
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1_000);
    localparam int unsigned WAKE_RX_CYC     = WAKE_RX_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        LPAM_RUN   = 2'b00,
        LPAM_DELAY = 2'b01,
        LPAM_SLEEP = 2'b10
    } lpam_state_e;

    typedef struct packed {
        logic act_alert;
        logic low_power_alert_message;
        logic count_reply;
    } lpam_msg_s;

endpackage : lpam_pkg

/* File: dv/lpam_host.sv */
// host and vehicle side model: bus pins, serial receive line and ignition line
`timescale 1ns/1ps
`default_nettype none
module lpam_host (
    input  wire logic  pclk,
    output logic [3:0] bus_in,
    output logic       bus_tx_active,
    output logic       bus_send_start,
    output logic       serial_rx,
    output logic       ignition_monitor_input
);
    initial begin
        bus_in = 4'h0;
        bus_tx_active = 1'h0;
        bus_send_start = 1'h0;
        serial_rx = 1'h1;
        ignition_monitor_input = 1'h1;
    end
    // active level on every bus pin; our own sends raise the transmit mask in the same cycle
    task automatic bus_burst(input logic own, input int len);
        @(posedge pclk);
        bus_in <= 4'hF;
        bus_tx_active <= own;
        bus_send_start <= own;
        @(posedge pclk);
        bus_send_start <= 1'h0;
        repeat (len) @(posedge pclk);
        bus_in <= 4'h0;
        // mask drops one cycle after the pins go quiet
        @(posedge pclk);
        bus_tx_active <= 1'h0;
    endtask
    task automatic rx_low(input int len);
        @(posedge pclk);
        serial_rx <= 1'h0;
        repeat (len) @(posedge pclk);
        serial_rx <= 1'h1;
    endtask
    task automatic ign(input logic lvl);
        @(posedge pclk);
        ignition_monitor_input <= lvl;
    endtask
endmodule // lpam_host
`default_nettype wire

/* File: dv/tb_top.sv */
// testbench: apb register tasks and standby entry and wake scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [11:0] A_CT = lpam_pkg::ADDR_CTRL;
    localparam logic [11:0] A_PA = lpam_pkg::ADDR_PARAM;
    localparam logic [11:0] A_TO = lpam_pkg::ADDR_TIMEOUT;
    localparam logic [11:0] A_ST = lpam_pkg::ADDR_STATUS;
    localparam logic [11:0] A_CN = lpam_pkg::ADDR_COUNT;
    localparam int          WAKE = lpam_pkg::WAKE_RX_CYC + 8;
    localparam int          STEP_C = 10;
    localparam int          POLL_C = 4;
    localparam int          LP_C   = 20;
    localparam int          ALT_C  = 30;
    localparam int          SEC_C  = 10;
    localparam int          DEB_C  = 3;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic [3:0]          bus_in;
    logic                bus_tx_active, bus_send_start, serial_rx, ign_in, clk_en;
    logic                standby, outputs_off, j1850_vctl, power_ctl;
    lpam_pkg::lpam_msg_s msg;
    int                  error_cnt, comparisons, cyc, n, k, n_act, n_lp;

    lpam_top #(.STEP_CYCLES(STEP_C), .POLL_CYCLES(POLL_C), .LP_CYCLES(LP_C), .ALERT_CYCLES(ALT_C),
        .SEC_CYCLES(SEC_C), .DEB_CYCLES(DEB_C)) lpam_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_in(bus_in), .bus_tx_active(bus_tx_active), .bus_send_start(bus_send_start),
        .serial_rx(serial_rx), .ignition_monitor_input(ign_in), .standby(standby), .outputs_off(outputs_off),
        .j1850_vctl(j1850_vctl), .power_ctl(power_ctl), .msg(msg));
    lpam_host lpam_host_i (.pclk(pclk), .bus_in(bus_in), .bus_tx_active(bus_tx_active),
        .bus_send_start(bus_send_start), .serial_rx(serial_rx), .ignition_monitor_input(ign_in));

    task automatic conclude();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        err = pslverr;
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // waits at most lim edges; n holds the edges taken
    task automatic wait_ev(input int sel, input int lim);
        n = 0;
        do begin
            @(posedge pclk);
            #1 n++;
        end while (n < lim && !(sel == 0 ? standby === 1'h1 : sel == 1 ? standby === 1'h0
                   : sel == 2 ? msg.act_alert === 1'h1 : msg.low_power_alert_message === 1'h1));
    endtask

    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (msg.act_alert === 1'h1) n_act++;
        if (msg.low_power_alert_message === 1'h1) n_lp++;
        if (cyc == 40000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        presetn = 1'h0;
        clk_en = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        #1 chk("vctl", j1850_vctl, 32'h1);
        chk("pwr", power_ctl, 32'h1);
        apb(1'h0, A_PA, 32'h0);
        chk("param", rd, 32'h0000F8FF);
        apb(1'h0, A_ST, 32'h0);
        chk("mon_en", rd[3], 32'h0);
        apb(1'h0, 12'h0FC, 32'h0);
        chk("slverr", err, 32'h1);
        apb(1'h1, A_PA, 32'h8880);
        lpam_host_i.bus_burst(1'h1, 8);
        apb(1'h0, A_ST, 32'h0);
        chk("mon_en", rd[3], 32'h1);
        k = n_act;
        repeat (400) @(posedge pclk);
        chk("act_alert", n_act > k, 32'h1);
        chk("no_sleep", standby, 32'h0);
        lpam_host_i.bus_burst(1'h1, 20);
        apb(1'h0, A_CN, 32'h0);
        chk("masked", rd[7:0] >= 8'h20, 32'h1);
        repeat (2800) @(posedge pclk);
        chk("ser_off", n_lp, 32'h0);
        apb(1'h0, A_CN, 32'h0);
        chk("sat", rd[7:0], 32'hFF);
        #1 chk("reply", msg.count_reply, 32'h1);
        lpam_host_i.bus_burst(1'h0, 8);
        apb(1'h0, A_CN, 32'h0);
        chk("clear", rd[7:0] <= 8'h1, 32'h1);
        repeat (100) @(posedge pclk);
        apb(1'h0, A_CN, 32'h0);
        chk("rate", rd[7:0] >= 8'h9 && rd[7:0] <= 8'hB, 32'h1);
        k = rd[7:0];
        clk_en <= 1'h0;
        repeat (60) @(posedge pclk);
        clk_en <= 1'h1;
        apb(1'h0, A_CN, 32'h0);
        chk("freeze", rd[7:0] <= k + 1, 32'h1);
        apb(1'h1, A_CT, 32'h4);
        repeat (30) @(posedge pclk);
        apb(1'h0, A_CN, 32'h0);
        chk("mon_off", rd[7:0], 32'h0);
        apb(1'h1, A_CT, 32'h0);
        apb(1'h1, A_PA, 32'hA080);
        apb(1'h1, A_TO, 32'h0);
        lpam_host_i.bus_burst(1'h0, 8);
        wait_ev(0, 600);
        chk("tmo_00", standby, 32'h0);
        apb(1'h1, A_TO, 32'h3);
        lpam_host_i.bus_burst(1'h0, 8);
        wait_ev(0, 200);
        chk("bus_lp", standby, 32'h1);
        apb(1'h1, A_CT, 32'h2);
        lpam_host_i.rx_low(60);
        chk("short_rx", standby, 32'h1);
        lpam_host_i.rx_low(WAKE);
        wait_ev(1, 20);
        chk("rx_wake", standby, 32'h0);
        lpam_host_i.bus_burst(1'h0, 8);
        wait_ev(0, 250);
        chk("dflt_wait", standby, 32'h0);
        wait_ev(0, 300);
        chk("dflt_lp", standby, 32'h1);
        apb(1'h1, A_PA, 32'h0080);
        lpam_host_i.rx_low(WAKE);
        wait_ev(1, 20);
        apb(1'h1, A_CT, 32'h1);
        wait_ev(0, 40);
        chk("lp_delay", n, LP_C);
        chk("off", outputs_off, 32'h1);
        chk("vctl", j1850_vctl, 32'h0);
        chk("pwr", power_ctl, 32'h0);
        lpam_host_i.ign(1'h0);
        repeat (20) @(posedge pclk);
        chk("ign_hold", standby, 32'h1);
        lpam_host_i.ign(1'h1);
        wait_ev(1, 40);
        chk("ign_wake", power_ctl, 32'h1);
        apb(1'h1, A_PA, 32'h0084);
        lpam_host_i.ign(1'h0);
        wait_ev(3, 40);
        chk("ign_alert", msg.low_power_alert_message, 32'h1);
        wait_ev(0, 40);
        chk("ign_lp", n >= 30 && n <= 32, 32'h1);
        lpam_host_i.ign(1'h1);
        wait_ev(1, 40);
        chk("ign_wake", standby, 32'h0);
        apb(1'h1, A_PA, 32'h00A8);
        lpam_host_i.rx_low(5);
        wait_ev(2, 2600);
        chk("warn_time", n >= 2380 && n <= 2420, 32'h1);
        wait_ev(3, 700);
        chk("exp_time", n >= 580 && n <= 620, 32'h1);
        wait_ev(0, 40);
        chk("ser_lp", n >= 30 && n <= 32, 32'h1);
        lpam_host_i.rx_low(WAKE);
        wait_ev(1, 20);
        apb(1'h1, A_PA, 32'h00B0);
        lpam_host_i.rx_low(5);
        k = n_lp + n_act;
        repeat (3200) @(posedge pclk);
        chk("long_tmo", n_lp + n_act, k);
        apb(1'h1, A_PA, 32'h0004);
        apb(1'h1, A_CT, 32'h1);
        lpam_host_i.ign(1'h0);
        wait_ev(0, 80);
        chk("master", standby, 32'h0);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
